// >>> hdl/psar_regs.sv
// Functional notes
// RQ1 - low write index addresses all 256 palette entries, 00..ff
// RQ2 - sprite writes use combined 14-bit write index 0000..3fff
// RQ3 - write index registers only store and return, no side effect
// RQ4 - palette read only via low read index; write prefetches then increments
// RQ5 - write to either sprite read index prefetches and increments as one
// RQ6 - pixel value ANDed with mask gives palette lookup index
// RQ7 - palette data reads the selected entry component, not last write
// RQ8 - enhanced variant keeps 8 bits, basic keeps top 6 bits
// RQ9 - order bit picks R,G,B or R,B,G,discard component sequence
// RQ10 - current component field: 00 red, 01 green, 10 blue, 11 discard
// RQ11 - red, green, blue holding registers are plain read/write storage
// RQ12 - cursor data reads selected buffer byte; low pixel in low bits
// RQ13 - cursor holding register is plain read/write storage
// RQ14 - blank bit forces red and blue converter outputs to zero
// RQ15 - terminal cursor register usable only while terminal mode enabled
// RQ16 - fixed colour bit selects bits 7-4 colour, else character foreground
// RQ17 - blink-off bit gives steady cursor, else blinks at terminal rate
// RQ18 - style bit: 0 forces foreground, 1 reverse video
// RQ19 - attribute enable gates all other terminal cursor fields
// RQ20 - clock choice decoded from programmable pick, second and first pick
// RQ21 - interrupting software saves and restores write index registers
// RQ22 - task switches must not reload read index registers
// RQ23 - monochrome software zeroes red/blue or sets the blank bit
// RQ24 - clock divider 00 factor 1, 01 factor 2, others reserved
// RQ25 - each data access advances component; wrap increments palette index
// RQ26 - each cursor data access increments index; reads refill holding
//
// Implementation choice: the plain strobed port.
`include "psar_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module psar_regs #(
    parameter bit ENHANCED = 1'b1
) (
    input  wire logic              clk,          // 20 MHz clock
    input  wire logic              rst_n,        // sync reset, active low
    input  wire logic [7:0]        addr,         // register index
    input  wire logic [7:0]        wdata,        // write data
    input  wire logic              wr,           // write strobe
    input  wire logic              rd,           // read strobe
    output logic      [7:0]        rdata,        // read data, next cycle
    input  wire logic              terminal_interactive, // pin, synchronised
    input  wire logic [7:0]        pixel,        // pixel from display memory
    input  wire logic [7:0]        dac_red_in,   // red converter input
    input  wire logic [7:0]        dac_blue_in,  // blue converter input
    input  wire logic [3:0]        char_fg,      // character foreground
    input  wire logic [3:0]        char_bg,      // character background
    input  wire logic              blink_phase,  // terminal blink rate
    input  wire logic              on_cursor,    // cell holds the cursor
    output logic      [7:0]        lookup_index, // masked palette index
    output logic      [7:0]        dac_red_out,  // red after blanking
    output logic      [7:0]        dac_blue_out, // blue after blanking
    output logic      [3:0]        cell_fg,      // displayed foreground
    output logic      [3:0]        cell_bg,      // displayed background
    output logic                   term_attr_on, // terminal attributes used
    output psar_pkg::psar_clk_t    clock_pick    // clock select fields
);
    // =====================================================
    // storage
    logic [7:0]  pal_mem [0:255][0:2];
    logic [7:0]  cur_mem [0:16383];
    logic [7:0]  widx_lo_q, widx_lo_d, widx_hi_q, widx_hi_d;
    logic [7:0]  ridx_lo_q, ridx_lo_d, ridx_hi_q, ridx_hi_d;
    logic [7:0]  mask_q, mask_d, blank_q, blank_d;
    logic [7:0]  clk1_q, clk1_d, clk2_q, clk2_d;
    logic        order_q, order_d;
    psar_pkg::psar_comp_t comp_q, comp_d;
    logic [7:0]  hold_q [0:2], hold_d [0:2];
    logic [7:0]  cur_hold_q, cur_hold_d;
    psar_pkg::psar_term_t term_q, term_d;
    logic [7:0]  rdata_d;
    logic        tsync_q1, tsync_q2;
    logic        pal_we, cur_we;
    logic [7:0]  pal_wval, lanes;
    logic [13:0] widx, ridx, widx_inc, ridx_inc;
    logic        data_acc, comp_wrap;
    psar_pkg::psar_comp_t comp_next;

    assign widx = {widx_hi_q[5:0], widx_lo_q};
    assign ridx = {ridx_hi_q[5:0], ridx_lo_q};
    assign widx_inc = widx + 14'h0001;
    assign ridx_inc = ridx + 14'h0001;
    // RQ8 basic variant keeps top 6 bits
    assign lanes = ENHANCED ? 8'hff : `PSAR_BASIC_KEEP;
    assign data_acc = (wr || rd) && addr == `PSAR_OFF_DATA;

    // =====================================================
    // component sequencing
    // RQ9 order selects sequence
    always_comb
    begin
        comp_next = psar_pkg::COMP_RED;
        comp_wrap = comp_q == psar_pkg::COMP_DISCARD
                    || (comp_q == psar_pkg::COMP_BLUE && !order_q);
        unique case (comp_q)
            psar_pkg::COMP_RED:
                comp_next = order_q ? psar_pkg::COMP_BLUE
                                    : psar_pkg::COMP_GREEN;
            psar_pkg::COMP_GREEN:
                comp_next = order_q ? psar_pkg::COMP_DISCARD
                                    : psar_pkg::COMP_BLUE;
            psar_pkg::COMP_BLUE:
                comp_next = order_q ? psar_pkg::COMP_GREEN
                                    : psar_pkg::COMP_RED;
            psar_pkg::COMP_DISCARD: comp_next = psar_pkg::COMP_RED;
        endcase
    end

    // =====================================================
    // register next state
    always_comb
    begin
        widx_lo_d  = widx_lo_q;
        widx_hi_d  = widx_hi_q;
        ridx_lo_d  = ridx_lo_q;
        ridx_hi_d  = ridx_hi_q;
        mask_d     = mask_q;
        blank_d    = blank_q;
        clk1_d     = clk1_q;
        clk2_d     = clk2_q;
        order_d    = order_q;
        comp_d     = comp_q;
        hold_d     = hold_q;
        cur_hold_d = cur_hold_q;
        term_d     = term_q;
        pal_we     = 1'b0;
        cur_we     = 1'b0;
        pal_wval   = wdata & lanes;
        rdata_d    = 8'h00;
        if (wr)
        begin
            unique case (addr)
                // RQ3 write index store only
                `PSAR_OFF_WIDX_LO: widx_lo_d = wdata;
                `PSAR_OFF_WIDX_HI: widx_hi_d = {2'b00, wdata[5:0]};
                // RQ4 prefetch then increment
                `PSAR_OFF_RIDX_LO:
                begin
                    hold_d = pal_mem[wdata];
                    // RQ5 combined index increment
                    {ridx_hi_d[5:0], ridx_lo_d} =
                        {ridx_hi_q[5:0], wdata} + 14'h0001;
                    cur_hold_d = cur_mem[{ridx_hi_q[5:0], wdata}];
                end
                `PSAR_OFF_RIDX_HI:
                begin
                    // RQ5 high write also prefetches
                    {ridx_hi_d[5:0], ridx_lo_d} =
                        {wdata[5:0], ridx_lo_q} + 14'h0001;
                    ridx_hi_d[7:6] = 2'b00;
                    cur_hold_d = cur_mem[{wdata[5:0], ridx_lo_q}];
                end
                `PSAR_OFF_MASK:  mask_d = wdata & lanes;
                // RQ10 field picks lane
                `PSAR_OFF_SEQ:
                begin
                    order_d = wdata[`PSAR_SEQ_ORDER_BIT];
                    comp_d  = psar_pkg::psar_comp_t'(wdata[1:0]);
                end
                // RQ11 plain holding storage
                `PSAR_OFF_RED_H: hold_d[0] = wdata;
                `PSAR_OFF_GRN_H: hold_d[1] = wdata;
                `PSAR_OFF_BLU_H: hold_d[2] = wdata;
                // RQ13 plain holding storage
                `PSAR_OFF_CUR_H: cur_hold_d = wdata;
                `PSAR_OFF_BLANK: blank_d = wdata;
                // RQ15 gated by terminal mode
                `PSAR_OFF_TERM:
                    if (tsync_q2)
                        term_d = psar_pkg::psar_term_t'(wdata);
                `PSAR_OFF_CLK1:  clk1_d = wdata;
                `PSAR_OFF_CLK2:  clk2_d = wdata;
                default: ;
            endcase
            // RQ1 palette write at low index
            if (addr == `PSAR_OFF_DATA && comp_q != psar_pkg::COMP_DISCARD)
                pal_we = 1'b1;
            // RQ2 cursor write at combined index
            if (addr == `PSAR_OFF_CUR_DATA)
            begin
                cur_we = 1'b1;
                {widx_hi_d[5:0], widx_lo_d} = widx_inc;
            end
        end
        // RQ25 advance component, wrap bumps index
        if (data_acc)
        begin
            comp_d = comp_next;
            if (comp_wrap && wr)
                widx_lo_d = widx_lo_q + 8'h01;
            if (comp_wrap && rd)
            begin
                ridx_lo_d = ridx_lo_q + 8'h01;
                hold_d = pal_mem[ridx_lo_q];
            end
        end
        if (rd)
        begin
            unique case (addr)
                `PSAR_OFF_WIDX_LO: rdata_d = widx_lo_q;
                `PSAR_OFF_WIDX_HI: rdata_d = widx_hi_q;
                `PSAR_OFF_RIDX_LO: rdata_d = ridx_lo_q;
                `PSAR_OFF_RIDX_HI: rdata_d = ridx_hi_q;
                `PSAR_OFF_MASK:    rdata_d = mask_q;
                // RQ7 returns selected component
                `PSAR_OFF_DATA:
                    rdata_d = (comp_q == psar_pkg::COMP_DISCARD) ? 8'h00
                              : hold_q[comp_q] & lanes;
                `PSAR_OFF_SEQ:
                    rdata_d = {5'b00000, order_q, comp_q};
                `PSAR_OFF_RED_H:   rdata_d = hold_q[0];
                `PSAR_OFF_GRN_H:   rdata_d = hold_q[1];
                `PSAR_OFF_BLU_H:   rdata_d = hold_q[2];
                // RQ12 reads prefetched buffer byte
                `PSAR_OFF_CUR_DATA:
                begin
                    rdata_d = cur_hold_q;
                    // RQ26 read refills and increments
                    {ridx_hi_d[5:0], ridx_lo_d} = ridx_inc;
                    cur_hold_d = cur_mem[ridx];
                end
                `PSAR_OFF_CUR_H:   rdata_d = cur_hold_q;
                `PSAR_OFF_BLANK:   rdata_d = blank_q;
                `PSAR_OFF_TERM:    rdata_d = tsync_q2 ? term_q : 8'h00;
                `PSAR_OFF_CLK1:    rdata_d = clk1_q;
                `PSAR_OFF_CLK2:    rdata_d = clk2_q;
                default:           rdata_d = 8'h00;
            endcase
        end
    end

    // =====================================================
    // registers
    always_ff @(posedge clk)
    begin
        tsync_q1 <= terminal_interactive;
        tsync_q2 <= tsync_q1;
        if (!rst_n)
        begin
            widx_lo_q  <= `PSAR_RESET_ZERO;
            widx_hi_q  <= `PSAR_RESET_ZERO;
            ridx_lo_q  <= `PSAR_RESET_ZERO;
            ridx_hi_q  <= `PSAR_RESET_ZERO;
            mask_q     <= `PSAR_RESET_MASK;
            blank_q    <= `PSAR_RESET_ZERO;
            clk1_q     <= `PSAR_RESET_ZERO;
            clk2_q     <= `PSAR_RESET_ZERO;
            order_q    <= 1'b0;
            comp_q     <= psar_pkg::COMP_RED;
            hold_q     <= '{default: `PSAR_RESET_ZERO};
            cur_hold_q <= `PSAR_RESET_ZERO;
            term_q     <= psar_pkg::psar_term_t'(`PSAR_RESET_ZERO);
            rdata      <= `PSAR_RESET_ZERO;
        end
        else
        begin
            widx_lo_q  <= widx_lo_d;
            widx_hi_q  <= widx_hi_d;
            ridx_lo_q  <= ridx_lo_d;
            ridx_hi_q  <= ridx_hi_d;
            mask_q     <= mask_d;
            blank_q    <= blank_d;
            clk1_q     <= clk1_d;
            clk2_q     <= clk2_d;
            order_q    <= order_d;
            comp_q     <= comp_d;
            hold_q     <= hold_d;
            cur_hold_q <= cur_hold_d;
            term_q     <= term_d;
            rdata      <= rdata_d;
        end
    end

    // memories have no reset; contents are software-loaded
    always_ff @(posedge clk)
    begin
        if (pal_we)
            pal_mem[widx_lo_q][comp_q] <= pal_wval;
        if (cur_we)
            cur_mem[widx] <= wdata;
    end

    // =====================================================
    // video path
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            lookup_index <= 8'h00;
            dac_red_out  <= 8'h00;
            dac_blue_out <= 8'h00;
            cell_fg      <= 4'h0;
            cell_bg      <= 4'h0;
            term_attr_on <= 1'b0;
            clock_pick   <= '0;
        end
        else
        begin
            // RQ6 masked lookup index
            lookup_index <= pixel & mask_q;
            // RQ14 red and blue blanking
            dac_red_out  <= blank_q[`PSAR_BLANK_BIT] ? 8'h00 : dac_red_in;
            dac_blue_out <= blank_q[`PSAR_BLANK_BIT] ? 8'h00 : dac_blue_in;
            // RQ19 attribute enable gates fields
            term_attr_on <= term_q.terminal_attr_enable;
            cell_fg <= char_fg;
            cell_bg <= char_bg;
            // RQ17 blink unless disabled
            if (term_q.terminal_attr_enable && on_cursor &&
                (term_q.cursor_blink_off || blink_phase))
            begin
                // RQ18 style: foreground or reverse
                if (term_q.cursor_style)
                begin
                    cell_fg <= char_bg;
                    cell_bg <= char_fg;
                end
                // RQ16 fixed colour or foreground
                else
                    cell_bg <= term_q.fixed_cursor_colour ? term_q.colour
                                                          : char_fg;
            end
            // RQ20 joint clock select fields
            clock_pick.programmable_clock_pick <=
                clk1_q[`PSAR_CLK1_PROG_LSB +: 2];
            clock_pick.clock_pick_second  <= clk2_q[`PSAR_CLK2_BIT];
            clock_pick.clock_pick_first   <= clk1_q[`PSAR_CLK1_PICK_LSB +: 2];
            clock_pick.video_clock_divider <= clk1_q[`PSAR_CLK1_DIV_LSB +: 2];
        end
    end

    // =====================================================
    // checks
    a_blank_forces_zero: // RQ14
    assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) && $past(blank_q[`PSAR_BLANK_BIT])
        |-> dac_red_out == 8'h00
        && dac_blue_out == 8'h00)
        else $error("blanked outputs not zero");
    a_mask_applied: // RQ6
    assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> lookup_index == ($past(pixel) & $past(mask_q)))
        else $error("lookup index not masked");
    a_widx_no_effect: // RQ3
    assert property (@(posedge clk) disable iff (!rst_n)
        wr && addr == `PSAR_OFF_WIDX_LO
        |=> $stable(ridx_lo_q) && $stable(comp_q))
        else $error("write index had side effect");
    a_ridx_increment: // RQ4
    assert property (@(posedge clk) disable iff (!rst_n)
        wr && addr == `PSAR_OFF_RIDX_LO
        |=> ridx_lo_q == $past(wdata) + 8'h01)
        else $error("read index not incremented");
    a_term_gated: // RQ15
    assert property (@(posedge clk) disable iff (!rst_n)
        !tsync_q2 |=> $stable(term_q))
        else $error("terminal register changed while disabled");
    a_comp_order: // RQ9
    assert property (@(posedge clk) disable iff (!rst_n)
        data_acc && order_q && comp_q == psar_pkg::COMP_RED
        |=> comp_q == psar_pkg::COMP_BLUE)
        else $error("wrong component order");
    a_comp_wrap: // RQ25
    assert property (@(posedge clk) disable iff (!rst_n)
        wr && addr == `PSAR_OFF_DATA && !order_q
        && comp_q == psar_pkg::COMP_BLUE
        |=> widx_lo_q == $past(widx_lo_q) + 8'h01)
        else $error("palette index not bumped on wrap");
    a_cursor_bump: // RQ26
    assert property (@(posedge clk) disable iff (!rst_n)
        wr && addr == `PSAR_OFF_CUR_DATA |=> widx == $past(widx_inc))
        else $error("cursor index not incremented");
endmodule
`default_nettype wire

// >>> inc/psar_cfg.svh
`ifndef PSAR_CFG_SVH
`define PSAR_CFG_SVH
`define PSAR_OFF_WIDX_LO  8'h60
`define PSAR_OFF_WIDX_HI  8'h61
`define PSAR_OFF_RIDX_LO  8'h62
`define PSAR_OFF_RIDX_HI  8'h63
`define PSAR_OFF_MASK     8'h64
`define PSAR_OFF_DATA     8'h65
`define PSAR_OFF_SEQ      8'h66
`define PSAR_OFF_RED_H    8'h67
`define PSAR_OFF_GRN_H    8'h68
`define PSAR_OFF_BLU_H    8'h69
`define PSAR_OFF_CUR_DATA 8'h6a
`define PSAR_OFF_CUR_H    8'h6b
`define PSAR_OFF_BLANK    8'h6c
`define PSAR_OFF_TERM     8'h6d
`define PSAR_OFF_CLK1     8'h54
`define PSAR_OFF_CLK2     8'h70
`define PSAR_SEQ_ORDER_BIT 2
`define PSAR_BLANK_BIT    0
`define PSAR_CLK2_BIT     7
`define PSAR_CLK1_PICK_LSB 2
`define PSAR_CLK1_PROG_LSB 6
`define PSAR_CLK1_DIV_LSB  0
`define PSAR_RESET_MASK   8'hff
`define PSAR_RESET_ZERO   8'h00
`define PSAR_IDX_MAX      14'h3fff
`define PSAR_BASIC_KEEP   8'hfc
`endif

// >>> inc/psar_pkg.sv
package psar_pkg;
    typedef enum logic [1:0] {COMP_RED, COMP_GREEN, COMP_BLUE, COMP_DISCARD}
        psar_comp_t;
    typedef struct packed {
        logic [3:0] colour;
        logic       fixed_cursor_colour;
        logic       cursor_blink_off;
        logic       cursor_style;
        logic       terminal_attr_enable;
    } psar_term_t;
    typedef struct packed {
        logic [1:0] programmable_clock_pick;
        logic       clock_pick_second;
        logic [1:0] clock_pick_first;
        logic [1:0] video_clock_divider;
    } psar_clk_t;
endpackage

// >>> tb/psar_regs_test.sv
`include "psar_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
`define PSAR_CHK(what, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("unexpected %s: exp %h seen %h", what, exp, got); \
        end \
    end
module psar_regs_test;
    // ======================================================
    // stimulus and observed signals
    logic                clk = 1'b0;
    logic                rst_n = 1'b0;
    logic [7:0]          addr = 8'h00;
    logic [7:0]          wdata = 8'h00;
    logic                wr = 1'b0;
    logic                rd = 1'b0;
    logic [7:0]          rdata;
    logic                term_en = 1'b0;
    logic [7:0]          pixel = 8'ha5;
    logic [7:0]          red_in = 8'h55;
    logic [7:0]          blue_in = 8'haa;
    logic [3:0]          fg = 4'h3;
    logic [3:0]          bg = 4'h5;
    logic                blink = 1'b1;
    logic                on_cur = 1'b1;
    logic [7:0]          lookup;
    logic [7:0]          red_out;
    logic [7:0]          blue_out;
    logic [3:0]          cell_fg;
    logic [3:0]          cell_bg;
    logic                attr_on;
    psar_pkg::psar_clk_t pick;
    int                  n_mismatch = 0;
    int                  n_checks = 0;
    int                  cycles = 0;

    psar_regs #(.ENHANCED(1'b1)) i_psar_regs (
        .clk                  (clk),
        .rst_n                (rst_n),
        .addr                 (addr),
        .wdata                (wdata),
        .wr                   (wr),
        .rd                   (rd),
        .rdata                (rdata),
        .terminal_interactive (term_en),
        .pixel                (pixel),
        .dac_red_in           (red_in),
        .dac_blue_in          (blue_in),
        .char_fg              (fg),
        .char_bg              (bg),
        .blink_phase          (blink),
        .on_cursor            (on_cur),
        .lookup_index         (lookup),
        .dac_red_out          (red_out),
        .dac_blue_out         (blue_out),
        .cell_fg              (cell_fg),
        .cell_bg              (cell_bg),
        .term_attr_on         (attr_on),
        .clock_pick           (pick)
    );

    always #25 clk = ~clk;

    // ======================================================
    // bus tasks and run control
    task automatic stop_test();
        if (n_mismatch == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // a hang costs one mismatch and ends the run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        `PSAR_CHK("rdata", exp, rdata)
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    // ======================================================
    // scenarios
    task automatic t_reset();
        rd_chk(`PSAR_OFF_MASK, 8'hff);
        rd_chk(`PSAR_OFF_SEQ, 8'h00);
        rd_chk(`PSAR_OFF_BLANK, 8'h00);
        `PSAR_CHK("lookup", 8'ha5, lookup)
    endtask

    task automatic t_index();
        wr_reg(`PSAR_OFF_WIDX_LO, 8'hff);
        wr_reg(`PSAR_OFF_WIDX_HI, 8'hff);
        rd_chk(`PSAR_OFF_WIDX_LO, 8'hff);
        rd_chk(`PSAR_OFF_WIDX_HI, 8'h3f);
        rd_chk(`PSAR_OFF_WIDX_LO, 8'hff);
        wr_reg(8'h71, 8'h5a);
        rd_chk(8'h71, 8'h00);
    endtask

    task automatic t_holding();
        logic [7:0] regs [4];
        regs = '{`PSAR_OFF_RED_H, `PSAR_OFF_GRN_H, `PSAR_OFF_BLU_H,
                 `PSAR_OFF_CUR_H};
        foreach (regs[i])
            wr_reg(regs[i], 8'hc0 + 8'(i));
        foreach (regs[i])
            rd_chk(regs[i], 8'hc0 + 8'(i));
        rd_chk(`PSAR_OFF_RIDX_LO, 8'h00);
        wr_reg(`PSAR_OFF_WIDX_LO, 8'hff);
        rd_chk(`PSAR_OFF_WIDX_LO, 8'hff);
    endtask

    task automatic t_pal_rgb();
        wr_reg(`PSAR_OFF_WIDX_LO, 8'h05);
        wr_reg(`PSAR_OFF_SEQ, 8'h00);
        wr_reg(`PSAR_OFF_DATA, 8'h11);
        wr_reg(`PSAR_OFF_DATA, 8'h22);
        wr_reg(`PSAR_OFF_DATA, 8'h33);
        rd_chk(`PSAR_OFF_SEQ, 8'h00);
        rd_chk(`PSAR_OFF_WIDX_LO, 8'h06);
        wr_reg(`PSAR_OFF_RIDX_LO, 8'h05);
        rd_chk(`PSAR_OFF_RIDX_LO, 8'h06);
        rd_chk(`PSAR_OFF_RED_H, 8'h11);
        rd_chk(`PSAR_OFF_GRN_H, 8'h22);
        rd_chk(`PSAR_OFF_BLU_H, 8'h33);
        rd_chk(`PSAR_OFF_DATA, 8'h11);
        rd_chk(`PSAR_OFF_DATA, 8'h22);
        rd_chk(`PSAR_OFF_DATA, 8'h33);
    endtask

    task automatic t_pal_rbg();
        wr_reg(`PSAR_OFF_WIDX_LO, 8'h07);
        wr_reg(`PSAR_OFF_SEQ, 8'h04);
        wr_reg(`PSAR_OFF_DATA, 8'haa);
        rd_chk(`PSAR_OFF_SEQ, 8'h06);
        wr_reg(`PSAR_OFF_DATA, 8'hbb);
        wr_reg(`PSAR_OFF_DATA, 8'hcc);
        rd_chk(`PSAR_OFF_SEQ, 8'h07);
        wr_reg(`PSAR_OFF_DATA, 8'hdd);
        rd_chk(`PSAR_OFF_WIDX_LO, 8'h08);
        wr_reg(`PSAR_OFF_RIDX_LO, 8'h07);
        rd_chk(`PSAR_OFF_RED_H, 8'haa);
        rd_chk(`PSAR_OFF_GRN_H, 8'hcc);
        rd_chk(`PSAR_OFF_BLU_H, 8'hbb);
        wr_reg(`PSAR_OFF_SEQ, 8'h00);
    endtask

    // read index low is 08 here, so the high write cannot carry
    task automatic t_cursor();
        wr_reg(`PSAR_OFF_WIDX_LO, 8'hff);
        wr_reg(`PSAR_OFF_WIDX_HI, 8'h3f);
        wr_reg(`PSAR_OFF_CUR_DATA, 8'h12);
        wr_reg(`PSAR_OFF_CUR_DATA, 8'h34);
        rd_chk(`PSAR_OFF_WIDX_LO, 8'h01);
        rd_chk(`PSAR_OFF_WIDX_HI, 8'h00);
        wr_reg(`PSAR_OFF_RIDX_HI, 8'h3f);
        wr_reg(`PSAR_OFF_RIDX_LO, 8'hff);
        rd_chk(`PSAR_OFF_CUR_H, 8'h12);
        rd_chk(`PSAR_OFF_RIDX_LO, 8'h00);
        rd_chk(`PSAR_OFF_RIDX_HI, 8'h00);
        rd_chk(`PSAR_OFF_CUR_DATA, 8'h12);
        rd_chk(`PSAR_OFF_CUR_H, 8'h34);
    endtask

    task automatic t_video();
        wr_reg(`PSAR_OFF_MASK, 8'h0f);
        pixel <= 8'hab;
        wr_reg(`PSAR_OFF_BLANK, 8'h01);
        settle();
        `PSAR_CHK("lookup", 8'h0b, lookup)
        `PSAR_CHK("red", 8'h00, red_out)
        `PSAR_CHK("blue", 8'h00, blue_out)
        wr_reg(`PSAR_OFF_BLANK, 8'h00);
        settle();
        `PSAR_CHK("red", 8'h55, red_out)
        `PSAR_CHK("blue", 8'haa, blue_out)
    endtask

    task automatic t_term();
        wr_reg(`PSAR_OFF_TERM, 8'h07);
        rd_chk(`PSAR_OFF_TERM, 8'h00);
        settle();
        `PSAR_CHK("attr", 1'b0, attr_on)
        `PSAR_CHK("fg", 4'h3, cell_fg)
        @(posedge clk);
        term_en <= 1'b1;
        repeat (4) @(posedge clk);
        wr_reg(`PSAR_OFF_TERM, 8'h07);
        rd_chk(`PSAR_OFF_TERM, 8'h07);
        settle();
        `PSAR_CHK("attr", 1'b1, attr_on)
        `PSAR_CHK("fg", 4'h5, cell_fg)
        `PSAR_CHK("bg", 4'h3, cell_bg)
        wr_reg(`PSAR_OFF_TERM, 8'ha9);
        settle();
        `PSAR_CHK("bg", 4'ha, cell_bg)
        `PSAR_CHK("fg", 4'h3, cell_fg)
        @(posedge clk);
        blink <= 1'b0;
        settle();
        `PSAR_CHK("bg", 4'h5, cell_bg)
        wr_reg(`PSAR_OFF_TERM, 8'h05);
        settle();
        `PSAR_CHK("bg", 4'h3, cell_bg)
    endtask

    task automatic t_clock();
        wr_reg(`PSAR_OFF_CLK1, 8'hcd);
        wr_reg(`PSAR_OFF_CLK2, 8'h80);
        settle();
        `PSAR_CHK("pick", 7'b1111101, pick)
    endtask

    // ======================================================
    // main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        `PSAR_CHK("rdata idle", 8'h00, rdata)
        t_reset();
        t_index();
        t_holding();
        t_pal_rgb();
        t_pal_rbg();
        t_cursor();
        t_video();
        t_term();
        t_clock();
        stop_test();
    end
endmodule
`default_nettype wire
